// ### inc/dbgp_pkg.sv
// Constants, register map and helper functions for the dual byte GPIO block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one word per register.
package dbgp_pkg;

   localparam int PORT_W = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFS_THIRD_DATA = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_THIRD_DIR = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_FOURTH_DATA = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_FOURTH_DIR = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_ANALOG_SEL = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h14;

   // Reset values.
   localparam logic [PORT_W-1:0] DIR_RESET = 8'hFF;
   localparam logic [2*PORT_W-1:0] ANALOG_RESET = 16'h0000;
   localparam logic CONFIG_LP_RESET = 1'b0;

   // Field positions, masks and the zero read value.
   localparam int ANALOG_THIRD_LSB = 0;
   localparam int ANALOG_FOURTH_LSB = 8;
   localparam int CONFIG_LP_BIT = 0;
   localparam logic [PORT_W-1:0] LP_DIR_MASK = 8'h03;
   localparam logic [PORT_W-1:0] GPIO_ONLY_MASK = 8'h1F;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_THIRD_DATA,
      SEL_THIRD_DIR,
      SEL_FOURTH_DATA,
      SEL_FOURTH_DIR,
      SEL_ANALOG,
      SEL_CONFIG
   } dbgp_sel_t;

   typedef enum {
      BUS_IDLE,
      BUS_ACK
   } dbgp_bus_st_t;

   function automatic dbgp_sel_t dbgp_decode(input logic [ADDR_W-1:0] addr);
      case (addr)
         OFS_THIRD_DATA: dbgp_decode = SEL_THIRD_DATA;
         OFS_THIRD_DIR: dbgp_decode = SEL_THIRD_DIR;
         OFS_FOURTH_DATA: dbgp_decode = SEL_FOURTH_DATA;
         OFS_FOURTH_DIR: dbgp_decode = SEL_FOURTH_DIR;
         OFS_ANALOG_SEL: dbgp_decode = SEL_ANALOG;
         OFS_CONFIG: dbgp_decode = SEL_CONFIG;
         default: dbgp_decode = SEL_NONE;
      endcase
   endfunction : dbgp_decode

   // Pin value as software sees it: analog pins read as zero.
   function automatic logic [PORT_W-1:0] dbgp_pin_view(input logic [PORT_W-1:0] pins,
                                                       input logic [PORT_W-1:0] analog);
      dbgp_pin_view = pins & ~analog;
   endfunction : dbgp_pin_view

endpackage : dbgp_pkg

// ### logic/dbgp_sync.sv
// Two-stage synchroniser for the sixteen pin inputs.
// Assumes the pins are asynchronous to i_ref_clk; no reset, the chain settles in two edges.
`timescale 1ns/1ns
module dbgp_sync (
   input wire logic i_ref_clk,
   input wire logic [2*dbgp_pkg::PORT_W-1:0] i_async,
   output logic [2*dbgp_pkg::PORT_W-1:0] o_sync
);
   import dbgp_pkg::*;

   logic [2*PORT_W-1:0] meta_reg;
   logic [2*PORT_W-1:0] sync_reg;

   // The first stage feeds only the second stage.
   always_ff @(posedge i_ref_clk) begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
   end

   assign o_sync = sync_reg;

endmodule : dbgp_sync

// ### logic/dbgp_gpio.sv
// Two 8-bit bidirectional GPIO ports with data latches and direction registers.
// Assumes an Avalon-MM master on i_ref_clk and a pad ring that resolves out/oe.
// Notes on behaviour
// (R1) Direction one tri-states the pin driver.
// (R2) Direction zero drives the output latch value.
// (R3) Data reads return pin states, not latch.
// (R4) Data writes are read-modify-write into latch.
// (R5) Direction controls driver even for analog pins.
// (R6) Analog pins read zero in data reads.
// (R7) Low-power crystal mode reads third direction[1:0] one.
// (R8) Reset sets directions; latches keep values.
// (R9) Eight-bit ports, direction bit per pin.
// (R10) Data bit reads pin high one, low zero.
// (R11) Fourth port low five pins plain GPIO; the code still lets analog_sel_reg[12:8] zero their data reads.
// (R12) Pin inputs pass a two-stage synchroniser.
`timescale 1ns/1ns
module dbgp_gpio (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [dbgp_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [dbgp_pkg::DATA_W-1:0] i_avs_writedata,
   input wire logic [dbgp_pkg::BE_W-1:0] i_avs_byteenable,
   output logic [dbgp_pkg::DATA_W-1:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic [dbgp_pkg::PORT_W-1:0] i_third_port_pin_bits,
   output logic [dbgp_pkg::PORT_W-1:0] o_third_port_pin_bits,
   output logic [dbgp_pkg::PORT_W-1:0] o_third_port_pin_oe,
   input wire logic [dbgp_pkg::PORT_W-1:0] i_fourth_port_pin_bits,
   output logic [dbgp_pkg::PORT_W-1:0] o_fourth_port_pin_bits,
   output logic [dbgp_pkg::PORT_W-1:0] o_fourth_port_pin_oe
);
   import dbgp_pkg::*;

   dbgp_bus_st_t state_reg;
   dbgp_bus_st_t state_next;
   logic [DATA_W-1:0] readdata_reg;
   logic [DATA_W-1:0] readdata_next;
   logic [PORT_W-1:0] third_port_direction_reg;
   logic [PORT_W-1:0] third_port_direction_next;
   logic [PORT_W-1:0] fourth_port_direction_reg;
   logic [PORT_W-1:0] fourth_port_direction_next;
   logic [2*PORT_W-1:0] analog_sel_reg;
   logic [2*PORT_W-1:0] analog_sel_next;
   logic low_power_crystal_osc_mode_reg;
   logic low_power_crystal_osc_mode_next;
   logic [PORT_W-1:0] third_latch_reg;
   logic [PORT_W-1:0] third_latch_next;
   logic [PORT_W-1:0] fourth_latch_reg;
   logic [PORT_W-1:0] fourth_latch_next;

   logic [2*PORT_W-1:0] pins_sync;
   logic [PORT_W-1:0] third_pins;
   logic [PORT_W-1:0] fourth_pins;
   logic [PORT_W-1:0] third_analog;
   logic [PORT_W-1:0] fourth_analog;
   logic [PORT_W-1:0] third_view;
   logic [PORT_W-1:0] fourth_view;
   logic [PORT_W-1:0] third_dir_view;
   dbgp_sel_t sel;
   logic wr_accept;

   // Pins are resampled before any use so reads never see a metastable level.
   dbgp_sync u_sync ( // R12
      .i_ref_clk(i_ref_clk),
      .i_async({i_fourth_port_pin_bits, i_third_port_pin_bits}),
      .o_sync(pins_sync)
   );

   assign third_pins = pins_sync[PORT_W-1:0];
   assign fourth_pins = pins_sync[2*PORT_W-1:PORT_W];
   assign third_analog = analog_sel_reg[ANALOG_THIRD_LSB +: PORT_W];
   assign fourth_analog = analog_sel_reg[ANALOG_FOURTH_LSB +: PORT_W];
   assign third_view = dbgp_pin_view(third_pins, third_analog); // R3 R6 R10
   assign fourth_view = dbgp_pin_view(fourth_pins, fourth_analog); // R3 R6 R10
   // The oscillator mode only masks the readback; the stored bits still steer the driver.
   assign third_dir_view = low_power_crystal_osc_mode_reg ?
                           (third_port_direction_reg | LP_DIR_MASK) :
                           third_port_direction_reg; // R7
   assign sel = dbgp_decode(i_avs_address);
   assign wr_accept = (state_reg == BUS_ACK) && i_avs_write;

   // Every access answers one edge after it is seen; waitrequest drops in BUS_ACK.
   always_comb begin
      state_next = state_reg;
      readdata_next = readdata_reg;
      case (state_reg)
         BUS_IDLE: begin
            if (i_avs_read || i_avs_write) begin
               state_next = BUS_ACK;
            end
            if (i_avs_read) begin
               case (sel)
                  SEL_THIRD_DATA: readdata_next = {24'h00_0000, third_view}; // R3
                  SEL_THIRD_DIR: readdata_next = {24'h00_0000, third_dir_view}; // R7
                  SEL_FOURTH_DATA: readdata_next = {24'h00_0000, fourth_view}; // R3
                  SEL_FOURTH_DIR: readdata_next = {24'h00_0000, fourth_port_direction_reg};
                  SEL_ANALOG: readdata_next = {16'h0000, analog_sel_reg};
                  SEL_CONFIG: readdata_next = {31'h0000_0000, low_power_crystal_osc_mode_reg};
                  default: readdata_next = READ_ZERO;
               endcase
            end
         end
         BUS_ACK: begin
            state_next = BUS_IDLE;
         end
         default: begin
            state_next = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         state_reg <= BUS_IDLE;
         readdata_reg <= READ_ZERO;
      end else begin
         state_reg <= state_next;
         readdata_reg <= readdata_next;
      end
   end

   assign o_avs_waitrequest = (state_reg != BUS_ACK);
   assign o_avs_readdata = readdata_reg;

   // Control registers; writes land on the edge where waitrequest is low.
   always_comb begin
      third_port_direction_next = third_port_direction_reg;
      fourth_port_direction_next = fourth_port_direction_reg;
      analog_sel_next = analog_sel_reg;
      low_power_crystal_osc_mode_next = low_power_crystal_osc_mode_reg;
      if (wr_accept) begin
         case (sel)
            SEL_THIRD_DIR: begin
               if (i_avs_byteenable[0]) begin
                  third_port_direction_next = i_avs_writedata[PORT_W-1:0]; // R9
               end
            end
            SEL_FOURTH_DIR: begin
               if (i_avs_byteenable[0]) begin
                  fourth_port_direction_next = i_avs_writedata[PORT_W-1:0]; // R9
               end
            end
            SEL_ANALOG: begin
               if (i_avs_byteenable[0]) begin
                  analog_sel_next[7:0] = i_avs_writedata[7:0];
               end
               if (i_avs_byteenable[1]) begin
                  analog_sel_next[15:8] = i_avs_writedata[15:8];
               end
            end
            SEL_CONFIG: begin
               if (i_avs_byteenable[0]) begin
                  low_power_crystal_osc_mode_next = i_avs_writedata[CONFIG_LP_BIT];
               end
            end
            default: begin
               third_port_direction_next = third_port_direction_reg;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         third_port_direction_reg <= DIR_RESET; // R8
         fourth_port_direction_reg <= DIR_RESET; // R8
         analog_sel_reg <= ANALOG_RESET;
         low_power_crystal_osc_mode_reg <= CONFIG_LP_RESET;
      end else begin
         third_port_direction_reg <= third_port_direction_next;
         fourth_port_direction_reg <= fourth_port_direction_next;
         analog_sel_reg <= analog_sel_next;
         low_power_crystal_osc_mode_reg <= low_power_crystal_osc_mode_next;
      end
   end

   // A write first reads the pins, so a disabled byte lane copies pin state
   // into the latch; software must set latches before turning pins to outputs.
   always_comb begin
      third_latch_next = third_latch_reg;
      fourth_latch_next = fourth_latch_reg;
      if (wr_accept && (sel == SEL_THIRD_DATA)) begin
         third_latch_next = i_avs_byteenable[0] ?
                            i_avs_writedata[PORT_W-1:0] : third_view; // R4
      end
      if (wr_accept && (sel == SEL_FOURTH_DATA)) begin
         fourth_latch_next = i_avs_byteenable[0] ?
                             i_avs_writedata[PORT_W-1:0] : fourth_view; // R4
      end
   end

   // Latches have no reset so their contents survive a warm reset.
   always_ff @(posedge i_ref_clk) begin
      third_latch_reg <= third_latch_next; // R8
      fourth_latch_reg <= fourth_latch_next; // R8
   end

   // Drivers follow the direction bits alone; analog select has no say. Data is
   // gated so an unknown latch never reaches a tri-stated pad.
   assign o_third_port_pin_oe = ~third_port_direction_reg; // R1 R5
   assign o_fourth_port_pin_oe = ~fourth_port_direction_reg; // R1 R5 R11
   assign o_third_port_pin_bits = third_latch_reg & ~third_port_direction_reg; // R2
   assign o_fourth_port_pin_bits = fourth_latch_reg & ~fourth_port_direction_reg; // R2

   // Checks.
   sequence s_wr(dbgp_sel_t s);
      (state_reg == BUS_ACK) && i_avs_write && (sel == s) && i_avs_byteenable[0];
   endsequence

   sequence s_rd_issue(dbgp_sel_t s);
      (state_reg == BUS_IDLE) && i_avs_read && (sel == s);
   endsequence

   property p_dir_hiz;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_wr(SEL_THIRD_DIR) |=> (o_third_port_pin_oe == ~$past(i_avs_writedata[7:0]));
   endproperty
   a_dir_hiz: assert property (p_dir_hiz) else $error("direction write did not steer oe"); // R1

   property p_drive_latch;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_wr(SEL_FOURTH_DATA) ##1 (fourth_port_direction_reg == 8'h00) |->
         (o_fourth_port_pin_bits == $past(i_avs_writedata[7:0]));
   endproperty
   a_drive_latch: assert property (p_drive_latch) else $error("output pin not latch value"); // R2

   property p_read_pins;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_rd_issue(SEL_THIRD_DATA) |=>
         (!o_avs_waitrequest && o_avs_readdata[7:0] == $past(third_view));
   endproperty
   a_read_pins: assert property (p_read_pins) else $error("data read not pin state"); // R3

   property p_rmw;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (wr_accept && sel == SEL_THIRD_DATA && !i_avs_byteenable[0]) |=>
         (third_latch_reg == $past(third_view));
   endproperty
   a_rmw: assert property (p_rmw) else $error("masked write did not copy pins"); // R4

   property p_analog_no_drive;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (wr_accept && sel == SEL_ANALOG) |=>
         ($stable(o_third_port_pin_oe) && $stable(o_fourth_port_pin_oe));
   endproperty
   a_analog_no_drive: assert property (p_analog_no_drive) else $error("analog changed oe"); // R5

   property p_analog_zero;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_rd_issue(SEL_FOURTH_DATA) |=> ((o_avs_readdata[7:0] & $past(fourth_analog)) == 8'h00);
   endproperty
   a_analog_zero: assert property (p_analog_zero) else $error("analog bit read nonzero"); // R6

   property p_lp_dir;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_rd_issue(SEL_THIRD_DIR) ##0 low_power_crystal_osc_mode_reg |=>
         (o_avs_readdata[1:0] == 2'b11);
   endproperty
   a_lp_dir: assert property (p_lp_dir) else $error("low-power mode direction readback"); // R7

   property p_reset_dir;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> (o_third_port_pin_oe == 8'h00 && o_fourth_port_pin_oe == 8'h00);
   endproperty
   a_reset_dir: assert property (p_reset_dir) else $error("pins not inputs after reset"); // R8

   property p_sync;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      ##2 (third_pins == $past(i_third_port_pin_bits, 2));
   endproperty
   a_sync: assert property (p_sync) else $error("pin sync latency not two"); // R12

   property p_fourth_dir;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_wr(SEL_FOURTH_DIR) |=> (o_fourth_port_pin_oe == ~$past(i_avs_writedata[7:0]));
   endproperty
   a_fourth_dir: assert property (p_fourth_dir) else $error("fourth oe not steered"); // R11

   // No disable here: the drivers must already be off while reset is still held.
   property p_reset_oe;
      @(posedge i_ref_clk)
      !i_rst_n |=> (o_third_port_pin_oe == 8'h00 && o_fourth_port_pin_oe == 8'h00);
   endproperty
   a_reset_oe: assert property (p_reset_oe) else $error("pins driven during reset"); // R8

   property p_lp_oe;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(low_power_crystal_osc_mode_reg) |-> $stable(o_third_port_pin_oe);
   endproperty
   a_lp_oe: assert property (p_lp_oe) else $error("oscillator mode moved oe"); // R7

   // A master is never held longer than one wait state, so no bus timeout is needed.
   sequence s_req_seen;
      (state_reg == BUS_IDLE) && (i_avs_read || i_avs_write);
   endsequence

   sequence s_ack_once;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence

   property p_one_wait;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_req_seen |=> s_ack_once;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("access not answered after one wait");

endmodule : dbgp_gpio

// ### verif/dbgp_pins.sv
// Board side of one 8-bit port: pull-up resistors and an external driver.
// Assumes the device driver wins wherever its output enable is high.
`timescale 1ns/1ns
module dbgp_pins (
   input wire logic [dbgp_pkg::PORT_W-1:0] i_out,
   input wire logic [dbgp_pkg::PORT_W-1:0] i_oe,
   input wire logic [dbgp_pkg::PORT_W-1:0] i_drv,
   input wire logic [dbgp_pkg::PORT_W-1:0] i_drv_en,
   output logic [dbgp_pkg::PORT_W-1:0] o_level
);
   import dbgp_pkg::*;
   // A released pin rises through its pull-up, so it never keeps the last driven value.
   always_comb begin
      for (int b = 0; b < PORT_W; b++) begin
         o_level[b] = i_oe[b] ? i_out[b] : (i_drv_en[b] ? i_drv[b] : 1'b1);
      end
   end
endmodule : dbgp_pins

// ### verif/dbgp_gpio_tb_top.sv
// Self-checking bench for the dual byte GPIO block.
// Assumes one board model on each port and an Avalon-MM master made of tasks.
`timescale 1ns/1ns
module dbgp_gpio_tb_top;
   import dbgp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [DATA_W-1:0] wdata = 32'h0000_0000;
   logic [BE_W-1:0] ben = 4'h0;
   logic [DATA_W-1:0] rdata;
   logic wreq;
   logic [PORT_W-1:0] p3, o3, e3, p4, o4, e4;
   logic [PORT_W-1:0] d3 = 8'h00;
   logic [PORT_W-1:0] de3 = 8'h00;
   logic [PORT_W-1:0] d4 = 8'h00;
   logic [PORT_W-1:0] de4 = 8'h00;
   logic [DATA_W-1:0] rdv;
   int n_fail = 0;
   int n_compared = 0;

   always #10 clk = ~clk;

   dbgp_gpio DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr),
      .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
      .i_avs_byteenable(ben), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
      .i_third_port_pin_bits(p3), .o_third_port_pin_bits(o3), .o_third_port_pin_oe(e3),
      .i_fourth_port_pin_bits(p4), .o_fourth_port_pin_bits(o4), .o_fourth_port_pin_oe(e4));
   dbgp_pins pins_third (.i_out(o3), .i_oe(e3), .i_drv(d3), .i_drv_en(de3), .o_level(p3));
   dbgp_pins pins_fourth (.i_out(o4), .i_oe(e4), .i_drv(d4), .i_drv_en(de4), .o_level(p4));

   task automatic summarize;
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   task automatic chk(input string name, input logic [DATA_W-1:0] seen,
                      input logic [DATA_W-1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // The slave answers after one wait state, but the bound leaves room for a slower one.
   task automatic wait_ack;
      int n;
      n = 0;
      @(posedge clk);
      while (wreq !== 1'b0) begin
         n++;
         if (n > 20) begin
            n_fail++;
            summarize();
         end
         @(posedge clk);
      end
   endtask : wait_ack

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [BE_W-1:0] be);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      ben <= be;
      wr_en <= 1'b1;
      wait_ack();
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      wait_ack();
      d = rdata;
      rd_en <= 1'b0;
   endtask : rd

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rd(OFS_THIRD_DIR, rdv);
      chk("dir3", rdv, 32'h0000_00FF);
      rd(OFS_FOURTH_DIR, rdv);
      chk("dir4", rdv, 32'h0000_00FF);
      chk("oe3", e3, 32'h0000_0000);
      chk("oe4", e4, 32'h0000_0000);
      rd(OFS_ANALOG_SEL, rdv);
      chk("analog", rdv, 32'h0000_0000);
      rd(OFS_CONFIG, rdv);
      chk("config", rdv, 32'h0000_0000);
      rd(OFS_THIRD_DATA, rdv);
      chk("data3 pulled", rdv, 32'h0000_00FF);
      // The read is seen two edges after the pins change, so it still shows the old level.
      d3 <= 8'hA5;
      de3 <= 8'hFF;
      rd(OFS_THIRD_DATA, rdv);
      chk("data3 sync", rdv, 32'h0000_00FF);
      rd(OFS_THIRD_DATA, rdv);
      chk("data3 pins", rdv, 32'h0000_00A5);
      // Latches are loaded before pins turn to outputs, so no unknown reaches a pad.
      wr(OFS_THIRD_DATA, 32'h0000_005A, 4'h1);
      wr(OFS_THIRD_DIR, 32'h0000_000F, 4'h1);
      @(negedge clk);
      chk("oe3 half", e3, 32'h0000_00F0);
      chk("out3", o3, 32'h0000_0050);
      repeat (2) @(posedge clk);
      rd(OFS_THIRD_DATA, rdv);
      chk("data3 mixed", rdv, 32'h0000_0055);
      wr(OFS_THIRD_DATA, 32'h0000_00FF, 4'h0);
      wr(OFS_THIRD_DIR, 32'h0000_0000, 4'h1);
      @(negedge clk);
      chk("out3 rmw", o3, 32'h0000_0055);
      chk("oe3 all", e3, 32'h0000_00FF);
      d4 <= 8'hC0;
      de4 <= 8'hFF;
      wr(OFS_FOURTH_DATA, 32'h0000_001F, 4'h1);
      wr(OFS_FOURTH_DIR, 32'h0000_00E0, 4'h1);
      @(negedge clk);
      chk("oe4 low", e4, 32'h0000_001F);
      chk("out4 low", o4, 32'h0000_001F);
      repeat (2) @(posedge clk);
      rd(OFS_FOURTH_DATA, rdv);
      chk("data4", rdv, 32'h0000_00DF);
      wr(OFS_ANALOG_SEL, 32'h0000_0281, 4'h3);
      rd(OFS_THIRD_DATA, rdv);
      chk("data3 analog", rdv, 32'h0000_0054);
      rd(OFS_FOURTH_DATA, rdv);
      chk("data4 analog", rdv, 32'h0000_00DD);
      @(negedge clk);
      chk("oe3 analog", e3, 32'h0000_00FF);
      wr(OFS_THIRD_DATA, 32'h0000_0000, 4'h0);
      @(negedge clk);
      chk("out3 analog rmw", o3, 32'h0000_0054);
      wr(OFS_CONFIG, 32'h0000_0001, 4'h1);
      rd(OFS_THIRD_DIR, rdv);
      chk("dir3 lp", rdv, 32'h0000_0003);
      chk("oe3 lp", e3, 32'h0000_00FF);
      wr(OFS_CONFIG, 32'h0000_0000, 4'h1);
      rd(OFS_THIRD_DIR, rdv);
      chk("dir3 no lp", rdv, 32'h0000_0000);
      wr(8'h20, 32'h0000_00FF, 4'hF);
      rd(8'h20, rdv);
      chk("unmapped", rdv, 32'h0000_0000);
      rd(OFS_FOURTH_DIR, rdv);
      chk("dir4 kept", rdv, 32'h0000_00E0);
      // A second reset must restore the directions but leave the latches alone.
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("oe3 reset", e3, 32'h0000_0000);
      rd(OFS_THIRD_DIR, rdv);
      chk("dir3 reset", rdv, 32'h0000_00FF);
      wr(OFS_THIRD_DIR, 32'h0000_0000, 4'h1);
      @(negedge clk);
      chk("out3 kept", o3, 32'h0000_0054);
      wr(OFS_FOURTH_DIR, 32'h0000_0000, 4'h1);
      wr(OFS_FOURTH_DATA, 32'h0000_003C, 4'h1);
      @(negedge clk);
      chk("out4 all", o4, 32'h0000_003C);
      chk("oe4 all", e4, 32'h0000_00FF);
      summarize();
   end
endmodule : dbgp_gpio_tb_top
